//--- rtl/adapter_io_direction_voltage.sv
`timescale 1ns/1ns
// Overview of operation
// - 32 single-ended lines plus 3 function lines
// - 16 differential lines plus 3 function lines
// - each line has its own direction bit
// - export clocks, pass received clock inward
// - independent inversion per exported clock
// - double-rate words tagged rising and falling
// - voltage by 10-bit code or family
// - five families: 1.2 1.5 1.8 2.5 3.3
// - one voltage for all single-ended lines
// - voltage and direction logic always present
module adapter_io_direction_voltage (
  // clock and reset
  input  wire logic                                     mclk_i,
  input  wire logic                                     reset_i,
  // user side: single-ended data
  input  wire logic [adapter_io_pkg::SE_WIDTH-1:0]      se_dir_word_i,
  input  wire logic [adapter_io_pkg::SE_WIDTH-1:0]      se_write_word_i,
  output logic      [adapter_io_pkg::SE_WIDTH-1:0]      se_read_word_o,
  // user side: differential data
  input  wire logic [adapter_io_pkg::DIFF_WIDTH-1:0]    diff_dir_word_i,
  input  wire logic [adapter_io_pkg::DIFF_WIDTH-1:0]    diff_write_word_i,
  output logic      [adapter_io_pkg::DIFF_WIDTH-1:0]    diff_read_word_o,
  // user side: function lines, both connectors
  input  wire logic [2*adapter_io_pkg::FUNC_WIDTH-1:0]  func_dir_i,
  input  wire logic [2*adapter_io_pkg::FUNC_WIDTH-1:0]  func_write_i,
  output logic      [2*adapter_io_pkg::FUNC_WIDTH-1:0]  func_read_o,
  // user side: clocks and double rate
  input  wire adapter_io_pkg::clk_ctl_t                 clk_ctl_i,
  input  wire logic                                     clk_out_en_i,
  output logic                                          link_clk_o,
  output adapter_io_pkg::ddr_word_t                     ddr_word_o,
  output logic                                          ddr_valid_o,
  // user side: voltage
  input  wire adapter_io_pkg::volt_req_t                volt_req_i,
  input  wire logic                                     volt_set_i,
  output logic                                          volt_done_o,
  // pins: single-ended connector
  input  wire logic [adapter_io_pkg::SE_WIDTH-1:0]      se_pin_i,
  output logic      [adapter_io_pkg::SE_WIDTH-1:0]      se_pin_o,
  output logic      [adapter_io_pkg::SE_WIDTH-1:0]      se_pin_oe_o,
  // pins: differential connector
  input  wire logic [adapter_io_pkg::DIFF_WIDTH-1:0]    diff_pin_i,
  output logic      [adapter_io_pkg::DIFF_WIDTH-1:0]    diff_pin_o,
  output logic      [adapter_io_pkg::DIFF_WIDTH-1:0]    diff_pin_oe_o,
  // pins: function lines
  input  wire logic [2*adapter_io_pkg::FUNC_WIDTH-1:0]  func_pin_i,
  output logic      [2*adapter_io_pkg::FUNC_WIDTH-1:0]  func_pin_o,
  output logic      [2*adapter_io_pkg::FUNC_WIDTH-1:0]  func_pin_oe_o,
  // pins: clocks
  input  wire logic                                     link_clk_i,
  output logic                                          se_clk_pin_o,
  output logic                                          diff_clk_pin_o,
  // pins: supply converter
  output logic [adapter_io_pkg::DAC_WIDTH-1:0]          dac_code_o,
  output logic                                          dac_load_o
);
  import adapter_io_pkg::*;

  typedef enum logic [1:0] {
    V_UNSET,
    V_LOAD,
    V_SETTLE,
    V_READY
  } vstate_t;

  // whole module state
  typedef struct packed {
    vstate_t                 vst;       // voltage sequencer
    logic [VCNT_W-1:0]       vcnt;      // settle counter
    logic                    ever_set;  // one setting done since reset
    logic [9:0]              dac;       // code on converter
    logic                    load;      // converter load strobe
    logic [SE_WIDTH-1:0]     se_s1;     // sync stage 1
    logic [SE_WIDTH-1:0]     se_s2;     // sync stage 2
    logic [DIFF_WIDTH-1:0]   df_s1;
    logic [DIFF_WIDTH-1:0]   df_s2;
    logic [5:0]              fn_s1;
    logic [5:0]              fn_s2;
    logic [2:0]              ck_s;      // two sync + edge history
    logic [SE_WIDTH-1:0]     se_rd;
    logic [DIFF_WIDTH-1:0]   df_rd;
    logic [5:0]              fn_rd;
    logic [SE_WIDTH-1:0]     se_out;
    logic [SE_WIDTH-1:0]     se_oe;
    logic [DIFF_WIDTH-1:0]   df_out;
    logic [DIFF_WIDTH-1:0]   df_oe;
    logic [5:0]              fn_out;
    logic [5:0]              fn_oe;
    logic                    ck_div;    // exported clock base
    logic                    se_ck;
    logic                    df_ck;
    logic                    lk_clk;
    ddr_word_t               ddr;
    logic                    ddr_v;
    logic                    done;      // settled flag behind done pin
  } state_t;

  state_t st_r;   // registered state
  state_t st_nxt; // next state

  // family to converter code
  function automatic logic [9:0] family_code(input family_t f);
    case (f)
      FAM_1V2: family_code = DAC_1V2;
      FAM_1V5: family_code = DAC_1V5;
      FAM_1V8: family_code = DAC_1V8;
      FAM_2V5: family_code = DAC_2V5;
      FAM_3V3: family_code = DAC_3V3;
      default: family_code = DAC_1V2; // unknown codes fall to lowest
    endcase
  endfunction

  // lines usable only after a completed setting
  logic ready; // lines usable

  // next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.load = 1'b0;
    ready = st_r.ever_set && (st_r.vst == V_READY);
    // voltage sequencer, one level for all lines
    case (st_r.vst)
      V_UNSET, V_READY: begin
        if (volt_set_i) begin
          st_nxt.dac = volt_req_i.use_code ? volt_req_i.code
                                           : family_code(volt_req_i.family);
          st_nxt.load = 1'b1;
          st_nxt.vst = V_LOAD;
        end
      end
      V_LOAD: begin
        st_nxt.vcnt = VCNT_W'(VSETTLE_CYC - 1);
        st_nxt.vst = V_SETTLE;
      end
      V_SETTLE: begin
        if (st_r.vcnt == '0) begin
          st_nxt.vst = V_READY;
          st_nxt.ever_set = 1'b1;
        end else begin
          st_nxt.vcnt = st_r.vcnt - VCNT_W'(1);
        end
      end
      default: st_nxt.vst = V_UNSET;
    endcase
    // pin synchronisers; only stage 2 is read
    // stage 1 may go metastable, so no logic looks at it
    st_nxt.se_s1 = se_pin_i;
    st_nxt.se_s2 = st_r.se_s1;
    st_nxt.df_s1 = diff_pin_i;
    st_nxt.df_s2 = st_r.df_s1;
    st_nxt.fn_s1 = func_pin_i;
    st_nxt.fn_s2 = st_r.fn_s1;
    st_nxt.ck_s = {st_r.ck_s[1:0], link_clk_i};
    // read words, whole-word access
    st_nxt.se_rd = st_r.se_s2;
    st_nxt.df_rd = st_r.df_s2;
    st_nxt.fn_rd = st_r.fn_s2;
    // drivers: per-bit direction, gated until voltage is set
    st_nxt.se_out = se_write_word_i;
    st_nxt.df_out = diff_write_word_i;
    st_nxt.fn_out = func_write_i;
    st_nxt.se_oe = ready ? se_dir_word_i : '0;
    st_nxt.df_oe = ready ? diff_dir_word_i : '0;
    st_nxt.fn_oe = ready ? func_dir_i : '0;
    // exported clocks at half fabric rate, each with own inversion
    st_nxt.ck_div = clk_out_en_i ? ~st_r.ck_div : 1'b0;
    st_nxt.se_ck = ready & (st_r.ck_div ^ clk_ctl_i.se_invert);
    st_nxt.df_ck = ready & (st_r.ck_div ^ clk_ctl_i.diff_invert);
    st_nxt.lk_clk = st_r.ck_s[1];
    // double rate: sample on both edges of received clock
    // edge history uses stage 2 onward, aligned with the data
    st_nxt.ddr_v = 1'b0;
    if (st_r.ck_s[1] && !st_r.ck_s[2]) begin
      st_nxt.ddr.se_rise = st_r.se_s2;
      st_nxt.ddr.diff_rise = st_r.df_s2;
    end else if (!st_r.ck_s[1] && st_r.ck_s[2]) begin
      st_nxt.ddr.se_fall = st_r.se_s2;
      st_nxt.ddr.diff_fall = st_r.df_s2;
      st_nxt.ddr_v = 1'b1; // pair complete on falling edge
    end
    // done registered from the next state so the pin is a flop
    st_nxt.done = st_nxt.ever_set && (st_nxt.vst == V_READY);
  end

  // state register
  // reset leaves drivers off and the converter at full scale
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.vst <= V_UNSET;
      st_r.dac <= DAC_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign se_read_word_o   = st_r.se_rd;
  assign diff_read_word_o = st_r.df_rd;
  assign func_read_o      = st_r.fn_rd;
  assign link_clk_o       = st_r.lk_clk;
  assign ddr_word_o       = st_r.ddr;
  assign ddr_valid_o      = st_r.ddr_v;
  assign volt_done_o      = st_r.done;
  assign se_pin_o         = st_r.se_out;
  assign se_pin_oe_o      = st_r.se_oe;
  assign diff_pin_o       = st_r.df_out;
  assign diff_pin_oe_o    = st_r.df_oe;
  assign func_pin_o       = st_r.fn_out;
  assign func_pin_oe_o    = st_r.fn_oe;
  assign se_clk_pin_o     = st_r.se_ck;
  assign diff_clk_pin_o   = st_r.df_ck;
  assign dac_code_o       = st_r.dac;
  assign dac_load_o       = st_r.load;

endmodule

//--- rtl/adapter_io_pkg.sv
package adapter_io_pkg;

  // connector widths
  localparam int SE_WIDTH   = 32;
  localparam int DIFF_WIDTH = 16;
  localparam int FUNC_WIDTH = 3;
  localparam int DAC_WIDTH  = 10;

  // direction bit values
  localparam logic DIR_INPUT  = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;

  // fabric clock period and direction settle time
  localparam int CLK_PERIOD_NS   = 100;
  localparam int DIR_SETTLE_NS   = 9;
  localparam int DIR_SETTLE_CYC  =
    (DIR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // converter settle time after a new voltage code
  localparam int VSETTLE_CYC = 16;
  localparam int VCNT_W      = 5;

  // logic family codes
  typedef enum logic [2:0] {
    FAM_1V2 = 3'h0,
    FAM_1V5 = 3'h1,
    FAM_1V8 = 3'h2,
    FAM_2V5 = 3'h3,
    FAM_3V3 = 3'h4
  } family_t;

  // converter codes per family (full scale 3.63 v)
  localparam logic [9:0] DAC_1V2 = 10'h152;
  localparam logic [9:0] DAC_1V5 = 10'h1a7;
  localparam logic [9:0] DAC_1V8 = 10'h1fb;
  localparam logic [9:0] DAC_2V5 = 10'h2c1;
  localparam logic [9:0] DAC_3V3 = 10'h3a2;
  localparam logic [9:0] DAC_RESET = 10'h3ff;

  // clock-out controls
  typedef struct packed {
    logic se_invert;
    logic diff_invert;
  } clk_ctl_t;

  // voltage request from user logic
  typedef struct packed {
    logic       use_code;
    family_t    family;
    logic [9:0] code;
  } volt_req_t;

  // double-rate capture word pair
  typedef struct packed {
    logic [SE_WIDTH-1:0]   se_rise;
    logic [SE_WIDTH-1:0]   se_fall;
    logic [DIFF_WIDTH-1:0] diff_rise;
    logic [DIFF_WIDTH-1:0] diff_fall;
  } ddr_word_t;

endpackage

//--- dv/adapter_io_props.sv
`timescale 1ns/1ns
// port-level timing watch on the io direction and voltage block
module adapter_io_props
  import adapter_io_pkg::*;
(
  // clock and reset
  input wire logic                     mclk_i,
  input wire logic                     reset_i,
  // user side
  input wire logic [31:0]              se_dir_word_i,
  input wire logic [15:0]              diff_dir_word_i,
  input wire adapter_io_pkg::clk_ctl_t  clk_ctl_i,
  input wire adapter_io_pkg::volt_req_t volt_req_i,
  input wire logic                     volt_set_i,
  input wire logic                     volt_done_o,
  input wire logic                     ddr_valid_o,
  // pins
  input wire logic [31:0]              se_pin_oe_o,
  input wire logic [15:0]              diff_pin_oe_o,
  input wire logic                     se_clk_pin_o,
  input wire logic                     diff_clk_pin_o,
  input wire logic [9:0]               dac_code_o,
  input wire logic                     dac_load_o
);
  // family order matches the enum encoding
  localparam logic [9:0] FAM_CODE [5] =
    '{DAC_1V2, DAC_1V5, DAC_1V8, DAC_2V5, DAC_3V3};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // two done samples so a rising or falling done never trips the enable checks
  oe_quiet_a: assert property (!volt_done_o && !$past(volt_done_o) |->
    se_pin_oe_o == '0 && diff_pin_oe_o == '0) else $error("drivers on");
  oe_dir_a: assert property (volt_done_o && $past(volt_done_o) |->
    se_pin_oe_o == $past(se_dir_word_i) &&
    diff_pin_oe_o == $past(diff_dir_word_i)) else $error("bad enables");
  load_pulse_a: assert property (dac_load_o |->
    $past(volt_set_i) ##1 !dac_load_o) else $error("bad load pulse");
  done_low_a: assert property (dac_load_o |=>
    !volt_done_o [*8]) else $error("done during settle");
  done_time_a: assert property (dac_load_o |->
    ##16 !volt_done_o ##1 volt_done_o) else $error("done late or early");
  fam_code_a: assert property (dac_load_o && !$past(volt_req_i.use_code)
    |-> dac_code_o == FAM_CODE[$past(volt_req_i.family)])
    else $error("bad family code");
  raw_code_a: assert property (dac_load_o && $past(volt_req_i.use_code)
    |-> dac_code_o == $past(volt_req_i.code)) else $error("bad raw code");
  dac_hold_a: assert property (!dac_load_o |->
    $stable(dac_code_o)) else $error("code moved without load");
  clk_inv_a: assert property (volt_done_o && $past(volt_done_o) |->
    (se_clk_pin_o ^ diff_clk_pin_o) == ^$past(clk_ctl_i))
    else $error("bad clock inversion");
  ddr_pulse_a: assert property (ddr_valid_o |=>
    !ddr_valid_o) else $error("valid too long");
  // main scenarios reached
  cover property (dac_load_o && volt_req_i.use_code);
  cover property ($rose(volt_done_o));
  cover property (ddr_valid_o);
endmodule
bind adapter_io_direction_voltage adapter_io_props adapter_io_props_i (.*);

//--- dv/far_side_model.sv
`timescale 1ns/1ns
// far-side circuitry: resolves each line, makes the received clock
module far_side_model (
  // pin side of the block
  input  wire logic [53:0] oe_i,
  input  wire logic [53:0] drv_i,
  // far-side levels and frame control
  input  wire logic [53:0] ext_i,
  input  wire logic        run_i,
  // resolved wires and received clock
  output wire logic [53:0] lvl_o,
  output logic             link_clk_o
);
  // a driven line shows the block's bit, else the far side's
  assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
  // 800 ns clock, odd phase, stands still outside frames
  initial begin
    link_clk_o = 1'b0;
    #37;
    forever begin
      #400;
      if (run_i) link_clk_o = ~link_clk_o;
    end
  end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ns
// self-checking bench for the io direction and voltage block
module testbench;
  import adapter_io_pkg::*;
  logic        mclk_i = 1'b0;  // fabric clock
  logic        reset_i = 1'b1; // sync reset
  logic [53:0] dir = '0;       // {se, diff, func} directions
  logic [53:0] wr = '0;        // {se, diff, func} write data
  logic [53:0] ext = '0;       // far-side levels
  wire  [53:0] oe, drv, lvl, rd;
  clk_ctl_t    ctl = '0;       // clock inversion
  logic        ck_en = 1'b0;   // clock export enable
  logic        run = 1'b0;     // link clock runs
  volt_req_t   req = '0;       // voltage request
  logic        vset = 1'b0;    // start voltage setting
  logic        done, load, dvalid, lclk, lclk_o, se_ck, df_ck, p;
  logic [1:0]  h;              // received clock, last two samples
  logic [9:0]  dac;            // converter code
  ddr_word_t   ddr;            // double-rate words
  int          errors = 0;
  int          n_compared = 0;
  int          n;
  logic [9:0]  codes [5] = '{DAC_1V2, DAC_1V5, DAC_1V8, DAC_2V5, DAC_3V3};
  adapter_io_direction_voltage adapter_io_direction_voltage_i (
    .mclk_i(mclk_i), .reset_i(reset_i),
    .se_dir_word_i(dir[53:22]), .se_write_word_i(wr[53:22]),
    .se_read_word_o(rd[53:22]), .diff_dir_word_i(dir[21:6]),
    .diff_write_word_i(wr[21:6]), .diff_read_word_o(rd[21:6]),
    .func_dir_i(dir[5:0]), .func_write_i(wr[5:0]), .func_read_o(rd[5:0]),
    .clk_ctl_i(ctl), .clk_out_en_i(ck_en), .link_clk_o(lclk_o),
    .ddr_word_o(ddr), .ddr_valid_o(dvalid), .volt_req_i(req),
    .volt_set_i(vset), .volt_done_o(done), .se_pin_i(lvl[53:22]),
    .se_pin_o(drv[53:22]), .se_pin_oe_o(oe[53:22]),
    .diff_pin_i(lvl[21:6]), .diff_pin_o(drv[21:6]),
    .diff_pin_oe_o(oe[21:6]), .func_pin_i(lvl[5:0]),
    .func_pin_o(drv[5:0]), .func_pin_oe_o(oe[5:0]), .link_clk_i(lclk),
    .se_clk_pin_o(se_ck), .diff_clk_pin_o(df_ck),
    .dac_code_o(dac), .dac_load_o(load));
  far_side_model far_side_model_i (.oe_i(oe), .drv_i(drv), .ext_i(ext),
    .run_i(run), .lvl_o(lvl), .link_clk_o(lclk));
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [111:0] g, input logic [111:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one setting: pulse start, code on load, done settle+1 after take
  task automatic set_volt(input volt_req_t r, input logic [9:0] e);
    int k;
    @(posedge mclk_i);
    req <= r;
    vset <= 1'b1;
    @(posedge mclk_i);
    vset <= 1'b0;
    k = 0;
    while (load !== 1'b1 && k < 9) begin
      @(negedge mclk_i);
      k++;
    end
    chk(dac, e);
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(negedge mclk_i);
      k++;
    end
    chk(k, VSETTLE_CYC + 1);
  endtask
  // direction mix; settle well past one cycle before relying on it
  task automatic io(input logic [53:0] d);
    @(posedge mclk_i);
    dir <= d;
    wr <= 54'h2c_93a5_0f1e_6b47;
    ext <= 54'h15_6c0f_9a33_d2e1;
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(oe, d);
    chk(drv & d, wr & d);
    chk(rd, (wr & d) | (ext & ~d));
  endtask
  task automatic test_done;
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    dir <= '1;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({oe, done, dac}, {54'h0, 1'b0, 10'h3ff});
    for (int i = 0; i < 5; i++) begin
      set_volt('{1'b0, family_t'(i), 10'h0}, codes[i]);
    end
    set_volt('{1'b1, FAM_1V2, 10'h2a5}, 10'h2a5);
    io(54'h3a_5a5a_0ff0_c3c3);
    io(~54'h3a_5a5a_0ff0_c3c3);
    io('0);
    @(posedge mclk_i);
    ctl <= '{1'b1, 1'b0};
    ck_en <= 1'b1;
    run <= 1'b1;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk_i);
      n += int'(dvalid === 1'b1);
      if (i == 20) p = se_ck;
      if (i == 21) chk({se_ck ^ p, se_ck ^ df_ck}, 2'b11);
      // passed clock lags the pin by two syncs and one register
      if (i >= 2) chk(lclk_o, h[1]);
      h = {h[0], lclk};
    end
    chk(n >= 4, 1'b1);
    chk(ddr, {ext[53:22], ext[53:22], ext[21:6], ext[21:6]});
    @(posedge mclk_i);
    run <= 1'b0;
    ctl <= '{1'b1, 1'b1};
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk(se_ck ^ df_ck, 1'b0);
    @(posedge mclk_i);
    ck_en <= 1'b0;
    repeat (3) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({se_ck, df_ck}, 2'b11);
    test_done;
  end
  // hang guard, about sixteen times the expected run
  initial begin
    repeat (3000) @(posedge mclk_i);
    errors++;
    test_done;
  end
endmodule
